// [core/ssb_pkg.sv]
package ssb_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [2:0] SSB_OFF_STATUS = 3'h0;
  localparam logic [2:0] SSB_OFF_DIVISOR = 3'h1;
  localparam logic [2:0] SSB_OFF_CONTROL = 3'h2;
  localparam logic [2:0] SSB_OFF_MODE = 3'h3;
  localparam logic [2:0] SSB_OFF_TX_HOLD = 3'h4;
  localparam logic [2:0] SSB_OFF_RX_HOLD = 3'h5;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SSB_B_TDE = 7;
  localparam int SSB_B_RDF = 6;
  localparam int SSB_B_OVR = 5;
  localparam int SSB_B_FRM = 4;
  localparam int SSB_B_PAR = 3;
  localparam int SSB_B_TCF = 2;
  localparam int SSB_B_MPR = 1;
  localparam int SSB_B_MPT = 0;
  localparam int SSB_B_TX_EN = 5;
  localparam int SSB_B_RX_EN = 4;
  localparam int SSB_B_AW_EN = 3;
  localparam int SSB_B_TDI_EN = 2;
  localparam int SSB_B_SYNC = 7;
  localparam int SSB_B_PRESCALE = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SSB_STATUS_RST = 8'h84;
  localparam logic [7:0] SSB_DIVISOR_RST = 8'hFF;
  localparam logic [7:0] SSB_CONTROL_RST = 8'h00;
  localparam logic [7:0] SSB_MODE_RST = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SSB_MCLK_HZ = 25000000;
  localparam logic [11:0] SSB_ASYNC_BASE = 12'h040;
  localparam logic [11:0] SSB_SYNC_BASE = 12'h008;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic {
    SSB_ASYNC = 1'b0,
    SSB_SYNC = 1'b1
  } ssb_mode_t;

  typedef struct packed {
    logic done;
    logic [7:0] data;
    logic mpb;
    logic framing_err;
    logic parity_err;
  } ssb_rx_evt_t;

  typedef struct packed {
    logic tx_holding_empty;
    logic rx_holding_full;
    logic overrun_flag;
    logic framing_flag;
    logic parity_flag;
    logic tx_complete_flag;
    logic rx_addr_marker_bit;
    logic tx_addr_marker_bit;
  } ssb_status_t;

endpackage

// [core/ssb_baud_gen.sv]
`timescale 1ns/10ps
module ssb_baud_gen (
  input wire logic mclk, // System clock
  input wire logic rst_n, // Synchronous reset
  input wire logic [7:0] divisor, // Divisor N
  input wire logic [1:0] prescale, // Prescale n
  input wire ssb_pkg::ssb_mode_t mode, // Async or clocked sync
  input wire logic restart, // Restart the count
  output logic bit_tick // One pulse per bit period
);
  import ssb_pkg::*;

  typedef struct packed {
    logic [11:0] pre_cnt;
    logic [7:0] div_cnt;
    logic tick;
  } ssb_bg_state_t;

  ssb_bg_state_t st;
  ssb_bg_state_t next_st;
  logic [11:0] unit_len;

  // ----------------------------------------------------------------
  // Unit of base x 2^(2n-1) clocks, counted N+1 times
  // ----------------------------------------------------------------
  always_comb begin
    unit_len = ((mode == SSB_SYNC) ? SSB_SYNC_BASE : SSB_ASYNC_BASE) >> 1;
    unit_len = unit_len << {prescale, 1'b0};
    next_st = st;
    next_st.tick = 1'b0;
    if (restart) begin
      next_st.pre_cnt = 12'h000;
      next_st.div_cnt = 8'h00;
    end else if (st.pre_cnt == unit_len - 12'h001) begin
      next_st.pre_cnt = 12'h000;
      if (st.div_cnt == divisor) begin
        next_st.div_cnt = 8'h00;
        next_st.tick = 1'b1;
      end else begin
        next_st.div_cnt = st.div_cnt + 8'h01;
      end
    end else begin
      next_st.pre_cnt = st.pre_cnt + 12'h001;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign bit_tick = st.tick;

endmodule // ssb_baud_gen

// [core/ssb_serial_status.sv]
`timescale 1ns/10ps
module ssb_serial_status (
  input wire logic mclk, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic [2:0] reg_addr, // Register address
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [7:0] reg_rdata, // Read data, cycle after strobe
  input wire logic tx_load, // Engine moved holding byte to shift register
  input wire logic tx_last_bit, // Engine sends last bit of a frame
  input wire ssb_pkg::ssb_rx_evt_t rx_evt, // Reception finished
  output logic [7:0] tx_data, // Transmit holding register
  output logic tx_addr_marker_bit, // Marker appended to transmit characters
  output logic tx_holding_empty, // Holding register has no data
  output logic tx_enable_bit, // Transmit enable
  output logic rx_enable_bit, // Receive enable
  output ssb_pkg::ssb_mode_t sync_mode, // Async or clocked sync
  output logic bit_tick, // One pulse per bit period
  output logic tx_done_irq // Transmit-done request
);
  import ssb_pkg::*;

  typedef struct packed {
    ssb_status_t status;
    logic [4:0] armed;
    logic [7:0] divisor;
    logic tx_en;
    logic rx_en;
    logic aw_en;
    logic tdi_en;
    ssb_mode_t mode;
    logic [1:0] prescale;
    logic [7:0] tx_hold;
    logic [7:0] rx_hold;
    logic [7:0] rdata;
    logic irq;
    logic restart;
  } ssb_state_t;

  ssb_state_t st;
  ssb_state_t next_st;
  logic [4:0] flags_now;
  logic [4:0] flag_clr;
  logic accept;
  logic discard;

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  function automatic logic hit(input logic strobe, input logic [2:0] addr, input logic [2:0] off);
    hit = strobe && (addr == off);
  endfunction

  function automatic logic [7:0] status_word(input ssb_status_t s);
    status_word = 8'h00;
    status_word[SSB_B_TDE] = s.tx_holding_empty;
    status_word[SSB_B_RDF] = s.rx_holding_full;
    status_word[SSB_B_OVR] = s.overrun_flag;
    status_word[SSB_B_FRM] = s.framing_flag;
    status_word[SSB_B_PAR] = s.parity_flag;
    status_word[SSB_B_TCF] = s.tx_complete_flag;
    status_word[SSB_B_MPR] = s.rx_addr_marker_bit;
    status_word[SSB_B_MPT] = s.tx_addr_marker_bit;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.restart = 1'b0;
    next_st.rdata = 8'h00;
    flags_now = {st.status.tx_holding_empty, st.status.rx_holding_full, st.status.overrun_flag,
      st.status.framing_flag, st.status.parity_flag};

    // Read side
    if (reg_rd) begin
      unique case (reg_addr)
        SSB_OFF_STATUS: next_st.rdata = status_word(st.status);
        SSB_OFF_DIVISOR: next_st.rdata = st.divisor;
        SSB_OFF_CONTROL: begin
          next_st.rdata[SSB_B_TX_EN] = st.tx_en;
          next_st.rdata[SSB_B_RX_EN] = st.rx_en;
          next_st.rdata[SSB_B_AW_EN] = st.aw_en;
          next_st.rdata[SSB_B_TDI_EN] = st.tdi_en;
        end
        SSB_OFF_MODE: begin
          next_st.rdata[SSB_B_SYNC] = st.mode;
          next_st.rdata[SSB_B_PRESCALE +: 2] = st.prescale;
        end
        SSB_OFF_TX_HOLD: next_st.rdata = st.tx_hold;
        SSB_OFF_RX_HOLD: next_st.rdata = st.rx_hold;
        default: next_st.rdata = 8'h00;
      endcase
    end

    // Arm each flag read as one
    if (hit(reg_rd, reg_addr, SSB_OFF_STATUS)) begin
      next_st.armed = st.armed | flags_now;
    end

    // Clear of a flag needs 0 written after it was read as 1
    flag_clr = 5'b00000;
    if (hit(reg_wr, reg_addr, SSB_OFF_STATUS)) begin
      flag_clr = ~reg_wdata[SSB_B_TDE:SSB_B_PAR] & st.armed;
      next_st.armed = next_st.armed & ~flag_clr;
      next_st.status.tx_addr_marker_bit = reg_wdata[SSB_B_MPT];
    end

    // Software clears
    if (flag_clr[4] || hit(reg_wr, reg_addr, SSB_OFF_TX_HOLD)) begin
      next_st.status.tx_holding_empty = 1'b0;
      next_st.status.tx_complete_flag = 1'b0;
    end
    if (flag_clr[3] || hit(reg_rd, reg_addr, SSB_OFF_RX_HOLD)) begin
      next_st.status.rx_holding_full = 1'b0;
    end
    if (flag_clr[2]) begin
      next_st.status.overrun_flag = 1'b0;
    end
    if (flag_clr[1]) begin
      next_st.status.framing_flag = 1'b0;
    end
    if (flag_clr[0]) begin
      next_st.status.parity_flag = 1'b0;
    end

    // Configuration writes
    if (hit(reg_wr, reg_addr, SSB_OFF_TX_HOLD)) begin
      next_st.tx_hold = reg_wdata;
    end
    if (hit(reg_wr, reg_addr, SSB_OFF_DIVISOR)) begin
      next_st.divisor = reg_wdata;
      next_st.restart = 1'b1;
    end
    if (hit(reg_wr, reg_addr, SSB_OFF_CONTROL)) begin
      next_st.tx_en = reg_wdata[SSB_B_TX_EN];
      next_st.rx_en = reg_wdata[SSB_B_RX_EN];
      next_st.aw_en = reg_wdata[SSB_B_AW_EN];
      next_st.tdi_en = reg_wdata[SSB_B_TDI_EN];
    end
    if (hit(reg_wr, reg_addr, SSB_OFF_MODE)) begin
      next_st.mode = ssb_mode_t'(reg_wdata[SSB_B_SYNC]);
      next_st.prescale = reg_wdata[SSB_B_PRESCALE +: 2];
      next_st.restart = 1'b1;
    end

    // Transmit side sets win over clears
    if (!st.tx_en || tx_load) begin
      next_st.status.tx_holding_empty = 1'b1;
    end
    if (!st.tx_en || (tx_last_bit && st.status.tx_holding_empty)) begin
      next_st.status.tx_complete_flag = 1'b1;
    end

    // Receive side sets win over clears
    accept = rx_evt.done && st.rx_en;
    discard = st.aw_en && !rx_evt.mpb;
    if (accept) begin
      next_st.status.rx_addr_marker_bit = rx_evt.mpb;
      if (st.aw_en && rx_evt.mpb) begin
        next_st.aw_en = 1'b0;
      end
      if (!discard) begin
        if (rx_evt.framing_err) begin
          next_st.status.framing_flag = 1'b1;
        end
        if (rx_evt.parity_err) begin
          next_st.status.parity_flag = 1'b1;
        end
        if (!rx_evt.framing_err && !rx_evt.parity_err) begin
          if (st.status.rx_holding_full) begin
            next_st.status.overrun_flag = 1'b1;
          end else begin
            next_st.status.rx_holding_full = 1'b1;
            next_st.rx_hold = rx_evt.data;
          end
        end
      end
    end

    // Arming lapses once a flag is low, so a fresh set needs a fresh read
    next_st.armed = next_st.armed & {next_st.status.tx_holding_empty, next_st.status.rx_holding_full,
      next_st.status.overrun_flag, next_st.status.framing_flag, next_st.status.parity_flag};

    next_st.irq = next_st.tdi_en && next_st.status.tx_complete_flag;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st <= '0;
      st.status <= ssb_status_t'(SSB_STATUS_RST);
      st.divisor <= SSB_DIVISOR_RST;
      st.tx_en <= SSB_CONTROL_RST[SSB_B_TX_EN];
      st.rx_en <= SSB_CONTROL_RST[SSB_B_RX_EN];
      st.aw_en <= SSB_CONTROL_RST[SSB_B_AW_EN];
      st.tdi_en <= SSB_CONTROL_RST[SSB_B_TDI_EN];
      st.mode <= ssb_mode_t'(SSB_MODE_RST[SSB_B_SYNC]);
      st.prescale <= SSB_MODE_RST[SSB_B_PRESCALE +: 2];
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Bit-rate generator
  // ----------------------------------------------------------------
  ssb_baud_gen u_baud (
    .mclk(mclk),
    .rst_n(rst_n),
    .divisor(st.divisor),
    .prescale(st.prescale),
    .mode(st.mode),
    .restart(st.restart),
    .bit_tick(bit_tick)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata = st.rdata;
  assign tx_data = st.tx_hold;
  assign tx_addr_marker_bit = st.status.tx_addr_marker_bit;
  assign tx_holding_empty = st.status.tx_holding_empty;
  assign tx_enable_bit = st.tx_en;
  assign rx_enable_bit = st.rx_en;
  assign sync_mode = st.mode;
  assign tx_done_irq = st.irq;

endmodule // ssb_serial_status

// [tb/ssb_serial_status_assertions.sv]
`timescale 1ns/10ps
module ssb_chk import ssb_pkg::*; (
  input wire logic mclk, // Clock
  input wire logic rst_n, // Reset
  input wire logic [2:0] reg_addr, // Address
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [7:0] reg_rdata, // Read data
  input wire logic tx_load, // Holding moved
  input wire logic [7:0] tx_data, // Holding register
  input wire logic tx_addr_marker_bit, // Tx marker
  input wire logic tx_holding_empty, // Tx empty
  input wire logic tx_enable_bit, // Tx enable
  input wire logic bit_tick, // Bit pulse
  input wire logic tx_done_irq // Tx done
);
  // ------------------------------
  // Properties
  // ------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data not idle");
  status_read_a: assert property (reg_rd && reg_addr == SSB_OFF_STATUS |=>
    reg_rdata[7] == $past(tx_holding_empty) && reg_rdata[0] == $past(tx_addr_marker_bit))
    else $error("status read wrong");
  unmapped_read_a: assert property (reg_rd && reg_addr > SSB_OFF_RX_HOLD |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  empty_off_a: assert property (!tx_enable_bit && !$past(tx_enable_bit) |-> tx_holding_empty)
    else $error("empty not forced");
  load_sets_a: assert property (tx_load |=> tx_holding_empty) else $error("load left empty low");
  hold_clears_a: assert property (reg_wr && reg_addr == SSB_OFF_TX_HOLD && tx_enable_bit && !tx_load
    |=> !tx_holding_empty) else $error("holding write kept empty");
  hold_data_a: assert property (reg_wr && reg_addr == SSB_OFF_TX_HOLD |=> tx_data == $past(reg_wdata))
    else $error("holding data wrong");
  marker_wr_a: assert property (reg_wr && reg_addr == SSB_OFF_STATUS |=>
    tx_addr_marker_bit == $past(reg_wdata[0])) else $error("tx marker wrong");
  irq_off_a: assert property (reg_wr && reg_addr == SSB_OFF_CONTROL && !reg_wdata[SSB_B_TDI_EN]
    |=> !tx_done_irq) else $error("irq while disabled");
  tick_gap_a: assert property (bit_tick |=> !bit_tick [*3]) else $error("bit pulses too close");
  irq_c: cover property ($rose(tx_done_irq));
  tick_c: cover property (bit_tick);
  load_c: cover property (tx_load);
endmodule // ssb_chk
bind ssb_serial_status ssb_chk u_chk (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_load(tx_load),
  .tx_data(tx_data), .tx_addr_marker_bit(tx_addr_marker_bit), .tx_holding_empty(tx_holding_empty),
  .tx_enable_bit(tx_enable_bit), .bit_tick(bit_tick), .tx_done_irq(tx_done_irq));

// [tb/ssb_engine_model.sv]
`timescale 1ns/10ps
module ssb_engine_model #(
  parameter int DLY = 6 // Cycles per transmit phase
) (
  input wire logic mclk, // Clock
  input wire logic tx_enable_bit, // Tx enable
  input wire logic tx_holding_empty, // Tx empty
  output logic tx_load, // Holding moved
  output logic tx_last_bit, // Last bit out
  output ssb_pkg::ssb_rx_evt_t rx_evt // Reception event
);
  import ssb_pkg::*;
  int cnt = 0;
  initial begin
    tx_load = 1'b0;
    tx_last_bit = 1'b0;
    rx_evt = '0;
  end
  // ------------------------------
  // Transmit engine
  // ------------------------------
  always @(posedge mclk) begin
    tx_load <= (cnt == DLY);
    tx_last_bit <= (cnt == 2 * DLY);
    if (cnt == 2 * DLY) begin
      cnt <= 0;
    end else if (cnt != 0 || (tx_enable_bit && !tx_holding_empty)) begin
      cnt <= cnt + 1;
    end
  end
  // Fields go inverse when no character stands
  task automatic rx_char(input logic [7:0] d, input logic m, input logic fe, input logic pe);
    @(posedge mclk);
    rx_evt <= {1'b1, d, m, fe, pe};
    @(posedge mclk);
    rx_evt <= {1'b0, ~d, ~m, ~fe, ~pe};
  endtask
endmodule // ssb_engine_model

// [tb/test_ssb_serial_status.sv]
`timescale 1ns/10ps
module test_ssb_serial_status;
  import ssb_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata, tx_data;
  logic tx_load, tx_last_bit, tx_addr_marker_bit, tx_holding_empty, tx_enable_bit, rx_enable_bit;
  logic bit_tick, tx_done_irq;
  ssb_rx_evt_t rx_evt;
  ssb_mode_t sync_mode;
  int err_total = 0;
  int comparisons = 0;
  int cycles = 0;
  always #20 mclk = ~mclk;
  ssb_serial_status uut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_load(tx_load), .tx_last_bit(tx_last_bit),
    .rx_evt(rx_evt), .tx_data(tx_data), .tx_addr_marker_bit(tx_addr_marker_bit),
    .tx_holding_empty(tx_holding_empty), .tx_enable_bit(tx_enable_bit), .rx_enable_bit(rx_enable_bit),
    .sync_mode(sync_mode), .bit_tick(bit_tick), .tx_done_irq(tx_done_irq));
  ssb_engine_model eng (.mclk(mclk), .tx_enable_bit(tx_enable_bit), .tx_holding_empty(tx_holding_empty),
    .tx_load(tx_load), .tx_last_bit(tx_last_bit), .rx_evt(rx_evt));
  // ------------------------------
  // Access tasks
  // ------------------------------
  task automatic stop_test;
    if (err_total == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      err_total++;
      stop_test();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input int a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= 3'(a);
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input int a, input logic [7:0] e);
    @(posedge mclk);
    reg_addr <= 3'(a);
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(16'(reg_rdata), 16'(e));
  endtask
  task automatic wait_irq;
    int c;
    c = 0;
    while (tx_done_irq !== 1'b1 && c < 100) begin
      @(posedge mclk);
      #1;
      c++;
    end
    chk(16'(tx_done_irq), 16'h0001);
  endtask
  task automatic rate(input logic [7:0] m, input logic [7:0] n, input int e);
    int c;
    wr(SSB_OFF_MODE, m);
    wr(SSB_OFF_DIVISOR, n);
    rd(SSB_OFF_DIVISOR, n);
    c = 0;
    while (bit_tick !== 1'b1 && c < 5000) begin
      @(posedge mclk);
      #1;
      c++;
    end
    c = 0;
    do begin
      @(posedge mclk);
      #1;
      c++;
    end while (bit_tick !== 1'b1 && c < 5000);
    chk(16'(c), 16'(e));
  endtask
  // ------------------------------
  // Tests
  // ------------------------------
  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    rd(0, 8'h84);
    rd(1, 8'hFF);
    rd(2, 8'h00);
    rd(3, 8'h00);
    wr(6, 8'hFF);
    rd(6, 8'h00);
    wr(0, 8'hFF);
    rd(0, 8'h85);
    wr(0, 8'h00);
    rd(0, 8'h84);
    wr(2, 8'h34);
    wr(4, 8'h5A);
    rd(0, 8'h00);
    chk(16'(tx_data), 16'h005A);
    wait_irq();
    rd(0, 8'h84);
    wr(0, 8'h80);
    rd(0, 8'h84);
    wr(0, 8'h00);
    rd(0, 8'h00);
    wait_irq();
    wr(2, 8'h14);
    eng.rx_char(8'h41, 1'b0, 1'b0, 1'b0);
    rd(0, 8'hC4);
    rd(5, 8'h41);
    rd(0, 8'h84);
    eng.rx_char(8'h42, 1'b0, 1'b0, 1'b0);
    wr(0, 8'h80);
    rd(0, 8'hC4);
    wr(0, 8'h80);
    rd(0, 8'h84);
    eng.rx_char(8'h43, 1'b0, 1'b0, 1'b0);
    eng.rx_char(8'h44, 1'b0, 1'b0, 1'b0);
    rd(0, 8'hE4);
    rd(5, 8'h43);
    eng.rx_char(8'h45, 1'b0, 1'b1, 1'b0);
    eng.rx_char(8'h46, 1'b0, 1'b0, 1'b1);
    rd(0, 8'hBC);
    rd(5, 8'h43);
    wr(0, 8'h80);
    rd(0, 8'h84);
    eng.rx_char(8'h47, 1'b1, 1'b0, 1'b0);
    rd(0, 8'hC6);
    rd(5, 8'h47);
    wr(2, 8'h04);
    eng.rx_char(8'h48, 1'b0, 1'b0, 1'b0);
    rd(0, 8'h86);
    chk(16'(rx_enable_bit), 16'h0000);
    wr(2, 8'h1C);
    eng.rx_char(8'h49, 1'b0, 1'b0, 1'b0);
    rd(0, 8'h84);
    eng.rx_char(8'h4A, 1'b1, 1'b0, 1'b0);
    rd(0, 8'hC6);
    rd(5, 8'h4A);
    rd(2, 8'h14);
    wr(2, 8'h10);
    rd(2, 8'h10);
    chk(16'(tx_done_irq), 16'h0000);
    rate(8'h00, 8'h01, 64);
    rate(8'h01, 8'h00, 128);
    rate(8'h03, 8'h00, 2048);
    rate(8'h80, 8'h02, 12);
    rate(8'h82, 8'h00, 64);
    rate(8'h80, 8'hFF, 1024);
    chk(16'(sync_mode), 16'h0001);
    stop_test();
  end
endmodule // test_ssb_serial_status
